// [rtl/bst_test_port.v]
`timescale 1ns/1ps
`default_nettype none
`include "bst_map.vh"
module bst_test_port #(
  parameter CHAIN_LEN = `BST_CHAIN_LEN,
  parameter HAS_USERCODE = 1,
  // Identity defaults are arbitrary values.
  parameter [3:0] ID_VERSION = 4'h5,
  parameter [15:0] ID_PART = 16'h1234,
  parameter [10:0] ID_MAKER = 11'h155,
  parameter [31:0] USERCODE_VALUE = 32'h0000_0000,
  parameter [15:0] USERSIG_VALUE = 16'h0000
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire port_enable_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  output wire tdo_o,
  output wire tdo_oe_b_o,
  input wire [CHAIN_LEN-1:0] pin_level_i,
  input wire [CHAIN_LEN-1:0] core_drive_i,
  output wire [CHAIN_LEN-1:0] pin_drive_o,
  output wire isp_active_o,
  output wire isp_load_o,
  output wire [`BST_ISP_LEN-1:0] isp_data_o
);

  // ----------------------------------------
  // TAP states
  // ----------------------------------------
  localparam [3:0] ST_RESET = 4'h0;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PA_DR = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'hA;
  localparam [3:0] ST_SH_IR = 4'hB;
  localparam [3:0] ST_EX1_IR = 4'hC;
  localparam [3:0] ST_PA_IR = 4'hD;
  localparam [3:0] ST_EX2_IR = 4'hE;
  localparam [3:0] ST_UPD_IR = 4'hF;

  localparam [2:0] SEL_BYP = 3'h0;
  localparam [2:0] SEL_ID = 3'h1;
  localparam [2:0] SEL_WORD = 3'h2;
  localparam [2:0] SEL_SIG = 3'h3;
  localparam [2:0] SEL_CHAIN = 3'h4;
  localparam [2:0] SEL_ISP = 3'h5;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // The port is oversampled, so TCK must stay well below a quarter of clk_i.
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg tck_last_reg;
  reg [CHAIN_LEN-1:0] lvl1_reg;
  reg [CHAIN_LEN-1:0] lvl2_reg;

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      tck_last_reg <= 1'b0;
      lvl1_reg <= {CHAIN_LEN{1'b0}};
      lvl2_reg <= {CHAIN_LEN{1'b0}};
    end
    else
    begin
      sync1_reg <= {port_enable_i, tck_i, tms_i, tdi_i};
      sync2_reg <= sync1_reg;
      tck_last_reg <= sync2_reg[2];
      lvl1_reg <= pin_level_i;
      lvl2_reg <= lvl1_reg;
    end
  end

  wire port_on = sync2_reg[3];
  wire tms = sync2_reg[1];
  wire tdi = sync2_reg[0];
  wire tck_rise = sync2_reg[2] & ~tck_last_reg;
  wire tck_fall = ~sync2_reg[2] & tck_last_reg;

  // ----------------------------------------
  // TAP controller
  // ----------------------------------------
  reg [3:0] state_reg;
  reg [3:0] state_next;

  always @*
  begin
    case (state_reg)
      ST_RESET: state_next = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: state_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: state_next = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_next = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_next = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: state_next = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_next = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_IDLE;
      default: state_next = ST_RESET;
    endcase
  end

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  reg [`BST_IR_LEN-1:0] ir_sh_reg;
  reg [`BST_IR_LEN-1:0] ir_reg;
  reg [2:0] sel;
  reg drive_test;

  always @*
  begin
    sel = SEL_BYP;
    drive_test = 1'b0;
    case (ir_reg)
      `BST_OP_EXTEST:
      begin
        sel = SEL_CHAIN;
        drive_test = 1'b1;
      end
      `BST_OP_SAMPLE: sel = SEL_CHAIN;
      `BST_OP_IDCODE: sel = SEL_ID;
      `BST_OP_USERCODE: sel = (HAS_USERCODE != 0) ? SEL_WORD : SEL_BYP;
      `BST_OP_USERSIG: sel = (HAS_USERCODE == 0) ? SEL_SIG : SEL_BYP;
      `BST_OP_ISP_DATA: sel = SEL_ISP;
      default: sel = SEL_BYP;
    endcase
  end

  // ----------------------------------------
  // Shift registers
  // ----------------------------------------
  wire [31:0] id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  reg byp_reg;
  reg [`BST_WORD_LEN-1:0] word_reg;
  reg [`BST_ISP_LEN-1:0] isp_sh_reg;
  reg [`BST_ISP_LEN-1:0] isp_data_reg;
  reg isp_load_reg;
  reg isp_active_reg;
  reg [CHAIN_LEN-1:0] chain_reg;
  reg [CHAIN_LEN-1:0] upd_reg;
  reg tdo_reg;
  reg tdo_oe_b_reg;

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= ST_RESET;
      ir_sh_reg <= {`BST_IR_LEN{1'b0}};
      ir_reg <= `BST_OP_IDCODE;
      byp_reg <= 1'b0;
      word_reg <= {`BST_WORD_LEN{1'b0}};
      isp_sh_reg <= {`BST_ISP_LEN{1'b0}};
      isp_data_reg <= {`BST_ISP_LEN{1'b0}};
      isp_load_reg <= 1'b0;
      isp_active_reg <= 1'b0;
      chain_reg <= {CHAIN_LEN{1'b0}};
      upd_reg <= {CHAIN_LEN{1'b0}};
      tdo_reg <= 1'b0;
      tdo_oe_b_reg <= 1'b1;
    end
    else if (!port_on)
    begin
      // A disabled port holds the TAP in reset so the pins are free for user logic.
      state_reg <= ST_RESET;
      ir_reg <= `BST_OP_IDCODE;
      isp_active_reg <= 1'b0;
      isp_load_reg <= 1'b0;
      tdo_oe_b_reg <= 1'b1;
    end
    else
    begin
      isp_load_reg <= 1'b0;
      if (tck_rise)
      begin
        state_reg <= state_next;
        case (state_reg)
          ST_CAP_IR: ir_sh_reg <= `BST_IR_CAPTURE;
          ST_SH_IR: ir_sh_reg <= {tdi, ir_sh_reg[`BST_IR_LEN-1:1]};
          ST_CAP_DR:
          begin
            byp_reg <= 1'b0;
            if (sel == SEL_ID)
              word_reg <= id_word;
            else if (sel == SEL_WORD)
              word_reg <= USERCODE_VALUE;
            else if (sel == SEL_SIG)
              word_reg <= {16'h0000, USERSIG_VALUE};
            if (sel == SEL_CHAIN)
              chain_reg <= lvl2_reg;
            if (sel == SEL_ISP)
              isp_sh_reg <= isp_data_reg;
          end
          ST_SH_DR:
          begin
            case (sel)
              SEL_BYP: byp_reg <= tdi;
              SEL_ID: word_reg <= {tdi, word_reg[31:1]};
              SEL_WORD: word_reg <= {tdi, word_reg[31:1]};
              SEL_SIG: word_reg <= {16'h0000, tdi, word_reg[15:1]};
              SEL_CHAIN: chain_reg <= {tdi, chain_reg[CHAIN_LEN-1:1]};
              SEL_ISP: isp_sh_reg <= {tdi, isp_sh_reg[`BST_ISP_LEN-1:1]};
              default: byp_reg <= tdi;
            endcase
          end
          default:
          begin
          end
        endcase
      end
      if (tck_fall)
      begin
        // Updates land on the falling edge; apart from TDO, outputs never move mid-shift.
        if (state_reg == ST_RESET)
        begin
          ir_reg <= `BST_OP_IDCODE;
          isp_active_reg <= 1'b0;
        end
        if (state_reg == ST_UPD_IR)
        begin
          ir_reg <= ir_sh_reg;
          if (ir_sh_reg == `BST_OP_ISP_ENTER)
            isp_active_reg <= 1'b1;
          if (ir_sh_reg == `BST_OP_ISP_EXIT)
            isp_active_reg <= 1'b0;
        end
        if (state_reg == ST_UPD_DR && sel == SEL_CHAIN)
          upd_reg <= chain_reg;
        if (state_reg == ST_UPD_DR && sel == SEL_ISP && isp_active_reg)
        begin
          isp_data_reg <= isp_sh_reg;
          isp_load_reg <= 1'b1;
        end
        tdo_oe_b_reg <= ~(state_reg == ST_SH_DR || state_reg == ST_SH_IR);
        if (state_reg == ST_SH_IR)
          tdo_reg <= ir_sh_reg[0];
        else
        begin
          case (sel)
            SEL_ID: tdo_reg <= word_reg[0];
            SEL_WORD: tdo_reg <= word_reg[0];
            SEL_SIG: tdo_reg <= word_reg[0];
            SEL_CHAIN: tdo_reg <= chain_reg[0];
            SEL_ISP: tdo_reg <= isp_sh_reg[0];
            default: tdo_reg <= byp_reg;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CHAIN_LEN; gi = gi + 1)
    begin : g_cell
      assign pin_drive_o[gi] = drive_test ? upd_reg[gi] : core_drive_i[gi];
    end
  endgenerate

  assign tdo_o = tdo_reg;
  assign tdo_oe_b_o = tdo_oe_b_reg;
  assign isp_active_o = isp_active_reg;
  assign isp_load_o = isp_load_reg;
  assign isp_data_o = isp_data_reg;

endmodule // bst_test_port
`default_nettype wire

// [rtl/bst_map.vh]
// Behaviour
// - The instruction register is ten bits long and shifts between TDI and TDO in the IR states.
// - SAMPLE/PRELOAD captures the pin levels into the chain and lets a pattern be preloaded.
// - EXTEST drives the chain's update values onto output pins and captures the input pins.
// - BYPASS puts one stage between TDI and TDO while normal operation continues.
// - IDCODE puts the identification register between TDI and TDO and shifts it out.
// - The identification word is version, part number, manufacturer and one final bit.
// - The identification word's least significant bit is one and leaves TDO first.
// - Where present, USERCODE selects a 32-bit user code register and shifts it out.
// - Without a user code register, a separate instruction reads a 16-bit user signature.
// - When the test port is disabled its four pins serve as ordinary user pins.
// - Programming instructions reach an in-system programming register through the port.
`ifndef BST_MAP_VH
`define BST_MAP_VH
`define BST_IR_LEN 10
`define BST_IR_CAPTURE 10'h001
`define BST_OP_EXTEST 10'h000
`define BST_OP_SAMPLE 10'h055
`define BST_OP_IDCODE 10'h059
`define BST_OP_USERCODE 10'h007
`define BST_OP_USERSIG 10'h079
`define BST_OP_ISP_ENTER 10'h2CC
`define BST_OP_ISP_DATA 10'h203
`define BST_OP_ISP_EXIT 10'h201
`define BST_OP_BYPASS 10'h3FF
`define BST_WORD_LEN 32
`define BST_SIG_LEN 16
`define BST_ISP_LEN 16
`define BST_CHAIN_LEN 96
`endif

// [testbench/bstp_test_port_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module bstp_checker (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic port_enable_i,
  input wire logic tck_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_b_o,
  input wire logic isp_active_o,
  input wire logic isp_load_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  rst_quiet_a:
    assert property ($rose(rst_b_i) |-> tdo_oe_b_o && !isp_active_o && !isp_load_o)
    else $error("outputs active right after reset");
  port_off_a:
    assert property (!port_enable_i [*4] |-> tdo_oe_b_o && !isp_active_o)
    else $error("test port active while disabled");
  isp_pulse_a:
    assert property (isp_load_o |=> !isp_load_o)
    else $error("load pulse longer than one cycle");
  isp_gate_a:
    assert property (isp_load_o |-> isp_active_o)
    else $error("load pulse outside programming mode");
  isp_fall_a:
    assert property (isp_load_o |-> !tck_i && !$past(tck_i, 2))
    else $error("load pulse not after a falling test clock");
  isp_on_a:
    assert property ($rose(isp_active_o) |-> $past(tck_i, 5) && !tck_i)
    else $error("programming mode entered off a falling edge");
  tdo_lat_a:
    assert property ($changed(tdo_o) && port_enable_i |-> $past(tck_i, 5) && !$past(tck_i, 2))
    else $error("serial output moved off a falling edge");
  oe_on_a:
    assert property ($fell(tdo_oe_b_o) |-> $past(tck_i, 5) ##1 !tdo_oe_b_o [*8])
    else $error("output enable timing wrong");
  oe_off_a:
    assert property ($rose(tdo_oe_b_o) && port_enable_i |-> !tck_i)
    else $error("output released while test clock high");
  cover property (isp_load_o);
  cover property ($fell(tdo_oe_b_o));
  cover property (!port_enable_i && tdo_oe_b_o);
endmodule // bstp_checker
bind bst_test_port bstp_checker chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .port_enable_i(port_enable_i), .tck_i(tck_i), .tdo_o(tdo_o), .tdo_oe_b_o(tdo_oe_b_o),
  .isp_active_o(isp_active_o), .isp_load_o(isp_load_o));
`default_nettype wire

// [testbench/bstp_jtag_host.sv]
`timescale 1ns/1ps
`default_nettype none
module bstp_jtag_host (
  input wire logic clk_i,
  input wire logic tdo_i,
  input wire logic tdo_oe_b_i,
  output var logic tck_o,
  output var logic tms_o,
  output var logic tdi_o
);
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // Called at a falling clk edge; a released output reads as unknown so it cannot match a driven 0 or 1.
  task automatic step(input logic m, input logic d, output logic q);
  begin
    tck_o = 1'b0;
    tms_o = m;
    tdi_o = d;
    repeat (6) @(negedge clk_i);
    q = tdo_oe_b_i ? 1'bx : tdo_i;
    tck_o = 1'b1;
    repeat (6) @(negedge clk_i);
    tck_o = 1'b0;
  end
  endtask
  task automatic tlr;
    logic q;
  begin
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  end
  endtask
  // Idle to idle scan, LSB first; the length must match the selected register.
  task automatic scan(input logic ir, input int n, input logic [95:0] din,
                      output logic [95:0] dout);
    logic q;
  begin
    dout = 96'h0;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  end
  endtask
endmodule // bstp_jtag_host
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bst_map.vh"
module tb_top;
  // Identity fields are arbitrary values.
  localparam logic [31:0] ID_WORD = {4'h2, 16'h4C4C, 11'h2AA, 1'b1};
  localparam logic [31:0] USER_WORD = 32'h5A5A_1234;
  localparam logic [95:0] LVL = {3{32'h1357_9BDF}};
  localparam logic [95:0] CORE = {3{32'h2468_ACE0}};
  localparam logic [95:0] PAT = {3{32'hF0E1_D2C3}};
  logic clk_i, rst_b_i, port_enable_i;
  logic [95:0] d;
  logic [41:0] rows [5];
  wire logic tck, tms, tdi, tdo, tdo_oe_b, isp_active, isp_load;
  wire logic [15:0] isp_data;
  wire logic [95:0] pin_drive;
  wire logic tck2, tms2, tdi2, tdo2, tdo_oe_b2;
  int miscompares = 0;
  int checks = 0;
  bst_test_port #(.CHAIN_LEN(96), .HAS_USERCODE(1), .ID_VERSION(ID_WORD[31:28]),
    .ID_PART(ID_WORD[27:12]), .ID_MAKER(ID_WORD[11:1]), .USERCODE_VALUE(USER_WORD),
    .USERSIG_VALUE(16'h3C3C)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .port_enable_i(port_enable_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_b_o(tdo_oe_b), .pin_level_i(LVL), .core_drive_i(CORE), .pin_drive_o(pin_drive),
    .isp_active_o(isp_active), .isp_load_o(isp_load), .isp_data_o(isp_data));
  bstp_jtag_host host_u (.clk_i(clk_i), .tdo_i(tdo), .tdo_oe_b_i(tdo_oe_b), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));
  // Second variant without a user code register, so the signature path is reached.
  bst_test_port #(.CHAIN_LEN(96), .HAS_USERCODE(0), .USERSIG_VALUE(16'h3C3C)) dut2_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .port_enable_i(port_enable_i), .tck_i(tck2),
    .tms_i(tms2), .tdi_i(tdi2), .tdo_o(tdo2), .tdo_oe_b_o(tdo_oe_b2), .pin_level_i(LVL),
    .core_drive_i(CORE), .pin_drive_o(), .isp_active_o(), .isp_load_o(), .isp_data_o());
  bstp_jtag_host host2_u (.clk_i(clk_i), .tdo_i(tdo2), .tdo_oe_b_i(tdo_oe_b2), .tck_o(tck2),
    .tms_o(tms2), .tdi_o(tdi2));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
  begin
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic ir(input logic [9:0] op);
  begin
    host_u.scan(1'b1, 10, {86'h0, op}, d);
  end
  endtask
  task automatic end_of_test;
  begin
    $display("miscompares %0d checks %0d", miscompares, checks);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    rst_b_i = 1'b0;
    port_enable_i = 1'b1;
    rows[0] = {`BST_OP_IDCODE, ID_WORD};
    rows[1] = {`BST_OP_USERCODE, USER_WORD};
    rows[2] = {`BST_OP_BYPASS, PAT[30:0], 1'b0};
    rows[3] = {`BST_OP_USERSIG, PAT[30:0], 1'b0};
    rows[4] = {10'h123, PAT[30:0], 1'b0};
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({94'h0, isp_active, tdo_oe_b}, 96'h1);
    host_u.tlr;
    host_u.scan(1'b0, 32, PAT, d);
    chk(d, {64'h0, ID_WORD});
    for (int r = 0; r < 5; r++)
    begin
      ir(rows[r][41:32]);
      chk(d, 96'h1);
      host_u.scan(1'b0, 32, PAT, d);
      chk(d, {64'h0, rows[r][31:0]});
    end
    ir(`BST_OP_SAMPLE);
    host_u.scan(1'b0, 96, PAT, d);
    chk(d, LVL);
    chk(pin_drive, CORE);
    ir(`BST_OP_EXTEST);
    chk(pin_drive, PAT);
    host_u.scan(1'b0, 96, ~PAT, d);
    chk(d, LVL);
    chk(pin_drive, ~PAT);
    host_u.tlr;
    chk(pin_drive, CORE);
    host_u.scan(1'b0, 32, PAT, d);
    chk(d, {64'h0, ID_WORD});
    ir(`BST_OP_ISP_DATA);
    host_u.scan(1'b0, 16, PAT, d);
    chk({79'h0, isp_active, isp_data}, 96'h0);
    ir(`BST_OP_ISP_ENTER);
    ir(`BST_OP_ISP_DATA);
    host_u.scan(1'b0, 16, PAT, d);
    chk({79'h0, isp_active, isp_data}, {79'h0, 1'b1, PAT[15:0]});
    rst_b_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({78'h0, isp_active, tdo_oe_b, isp_data}, {78'h0, 2'b01, 16'h0000});
    host_u.tlr;
    ir(`BST_OP_ISP_EXIT);
    chk({95'h0, isp_active}, 96'h0);
    host2_u.tlr;
    host2_u.scan(1'b1, 10, {86'h0, `BST_OP_USERSIG}, d);
    chk(d, 96'h1);
    host2_u.scan(1'b0, 16, PAT, d);
    chk(d, {80'h0, 16'h3C3C});
    host2_u.scan(1'b1, 10, {86'h0, `BST_OP_USERCODE}, d);
    host2_u.scan(1'b0, 32, PAT, d);
    chk(d, {64'h0, PAT[30:0], 1'b0});
    port_enable_i = 1'b0;
    ir(`BST_OP_BYPASS);
    chk(d, {86'h0, {10{1'bx}}});
    end_of_test;
  end
  initial
  begin
    #200000;
    miscompares++;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
